// >>> rx_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
  logic                  rxPin;
  logic                  irMode;
  logic                  rxInvert;
  uart_pins_pkg::byte_t  rxData;
  logic                  rxStrobe;

  modport owner (output rxPin, output irMode, output rxInvert, input rxData, input rxStrobe);
  modport receiver (input rxPin, input irMode, input rxInvert, output rxData, output rxStrobe);
endinterface : rx_link_if
`default_nettype wire

// >>> serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Clock
  input  wire logic clk,
  // Line
  input  wire logic serialOut,
  output var logic  serialIn
);
  initial serialIn = 1'b1;
  // Infrared idle follows the polarity so the line never rests inside a pulse
  task automatic idle(input logic ir, input logic inv);
    @(posedge clk);
    serialIn <= ir ? inv : 1'b1;
  endtask : idle
  task automatic sendFrame(input logic [7:0] d, input logic ir, input logic inv);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        if (ir) serialIn <= inv ^ (!f[i] && c < 3);
        else serialIn <= f[i];
      end
    end
  endtask : sendFrame
  // Windows align to the start pulse, so any pulse offset within a bit works
  task automatic recvFrame(input logic ir, output logic [7:0] d);
    logic hi;
    for (int n = 0; n < 400 && serialOut !== ir; n++) @(posedge clk);
    repeat (15) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      hi = 1'b0;
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        if (ir) hi = hi | serialOut;
        else if (c == 8) hi = !serialOut;
      end
      d[k] = !hi;
    end
  endtask : recvFrame
endmodule : serial_peer
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                    clk, reset_n, regWrite, regRead, serialOut, serialIn, clearSendN;
  logic                    requestSendN, terminalReadyN, setReadyN, carrierDetectN;
  logic                    ringIndicateN, irqOut, irqOutEn, outputPortTwoN, rxReadyN;
  logic [7:0]              regRdata;
  uart_pins_pkg::regAddr_t regAddr;
  uart_pins_pkg::byte_t    regWdata;
  int                      badCount;
  int                      testsRun;
  uart_serial_modem_pins uart_serial_modem_pins_i (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .serialOut(serialOut), .serialIn(serialIn),
    .requestSendN(requestSendN), .clearSendN(clearSendN), .terminalReadyN(terminalReadyN),
    .setReadyN(setReadyN), .carrierDetectN(carrierDetectN), .ringIndicateN(ringIndicateN),
    .irqOut(irqOut), .irqOutEn(irqOutEn), .outputPortTwoN(outputPortTwoN),
    .rxReadyN(rxReadyN));
  serial_peer serial_peer_i (.clk(clk), .serialOut(serialOut), .serialIn(serialIn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wr(input uart_pins_pkg::regAddr_t a, input uart_pins_pkg::byte_t d);
    @(posedge clk);
    {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input uart_pins_pkg::regAddr_t a, output uart_pins_pkg::byte_t d);
    @(posedge clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : rd
  task automatic chkByte(input uart_pins_pkg::byte_t got, input uart_pins_pkg::byte_t exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask : chkBit
  task automatic chkReg(input uart_pins_pkg::regAddr_t a, input uart_pins_pkg::byte_t exp);
    uart_pins_pkg::byte_t d;
    rd(a, d);
    chkByte(d, exp);
  endtask : chkReg
  // Done is seen as the interrupt, so the mask for it must already be set
  task automatic txDone;
    for (int n = 0; n < 200 && irqOut !== 1'b1; n++) @(posedge clk);
    chkBit(irqOut, 1'b1);
    wr(uart_pins_pkg::ADDR_IRQ_STATUS, 8'hff);
  endtask : txDone
  task automatic testReset;
    @(negedge clk);
    chkBit(serialOut, 1'b1);
    chkBit(terminalReadyN & rxReadyN & requestSendN, 1'b1);
    chkBit(outputPortTwoN, 1'b1);
    chkBit(irqOutEn, 1'b0);
    for (int a = 1; a < 8; a++) chkReg(a[2:0], 8'h00);
    $display("testReset done");
  endtask : testReset
  task automatic testModem;
    uart_pins_pkg::byte_t v [5] = '{8'h01, 8'h02, 8'h08, 8'h0b, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(uart_pins_pkg::ADDR_MODEM_CTRL, v[i]);
      @(negedge clk);
      chkBit(terminalReadyN, !v[i][0]);
      chkBit(requestSendN, !v[i][1]);
      chkBit(outputPortTwoN, !v[i][3]);
      chkBit(irqOutEn, v[i][3]);
      chkReg(uart_pins_pkg::ADDR_MODEM_CTRL, v[i]);
    end
    $display("testModem done");
  endtask : testModem
  task automatic testStatus;
    @(posedge clk);
    {clearSendN, setReadyN, carrierDetectN, ringIndicateN} <= 4'h0;
    repeat (8) @(posedge clk);
    chkReg(uart_pins_pkg::ADDR_MODEM_STAT, 8'hf0);
    chkReg(uart_pins_pkg::ADDR_IRQ_STATUS, 8'h1e);
    chkBit(serialOut & requestSendN, 1'b1);
    wr(uart_pins_pkg::ADDR_MODEM_STAT, 8'h00);
    chkReg(uart_pins_pkg::ADDR_MODEM_STAT, 8'hf0);
    @(posedge clk);
    {clearSendN, setReadyN, carrierDetectN, ringIndicateN} <= 4'hf;
    repeat (8) @(posedge clk);
    wr(uart_pins_pkg::ADDR_IRQ_STATUS, 8'hff);
    chkReg(uart_pins_pkg::ADDR_IRQ_STATUS, 8'h00);
    $display("testStatus done");
  endtask : testStatus
  task automatic testTxStd;
    logic [7:0] d;
    wr(uart_pins_pkg::ADDR_FEATURE, 8'h08);
    wr(uart_pins_pkg::ADDR_IRQ_MASK, 8'h20);
    wr(uart_pins_pkg::ADDR_DATA, 8'ha5);
    serial_peer_i.recvFrame(1'b0, d);
    chkByte(d, 8'ha5);
    chkBit(requestSendN, 1'b0);
    for (int n = 0; n < 200 && irqOut !== 1'b1; n++) @(posedge clk);
    wr(uart_pins_pkg::ADDR_IRQ_MASK, 8'h00);
    // The mask lands on the write edge, so look once it has settled
    @(negedge clk);
    chkBit(irqOut, 1'b0);
    wr(uart_pins_pkg::ADDR_IRQ_MASK, 8'h20);
    txDone;
    @(negedge clk);
    chkBit(irqOut, 1'b0);
    chkBit(requestSendN, 1'b1);
    chkBit(serialOut, 1'b1);
    wr(uart_pins_pkg::ADDR_FEATURE, 8'h00);
    $display("testTxStd done");
  endtask : testTxStd
  task automatic testCts;
    logic [7:0] d;
    logic       still;
    still = 1'b1;
    wr(uart_pins_pkg::ADDR_ENHANCED, 8'h80);
    wr(uart_pins_pkg::ADDR_DATA, 8'h3c);
    repeat (80) @(posedge clk) still = still & serialOut;
    chkBit(still, 1'b1);
    clearSendN <= 1'b0;
    serial_peer_i.recvFrame(1'b0, d);
    chkByte(d, 8'h3c);
    txDone;
    wr(uart_pins_pkg::ADDR_ENHANCED, 8'h00);
    $display("testCts done");
  endtask : testCts
  task automatic testTxIr;
    logic [7:0] d;
    wr(uart_pins_pkg::ADDR_MODEM_CTRL, 8'h40);
    serial_peer_i.idle(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chkBit(serialOut, 1'b0);
    wr(uart_pins_pkg::ADDR_DATA, 8'h96);
    serial_peer_i.recvFrame(1'b1, d);
    chkByte(d, 8'h96);
    txDone;
    @(negedge clk);
    chkBit(serialOut, 1'b0);
    $display("testTxIr done");
  endtask : testTxIr
  // Mode switches can frame noise, so settle and flush before the real byte
  task automatic testRx;
    logic [7:0] d;
    // Automatic request-to-send rides along: a waiting byte must pull it back
    wr(uart_pins_pkg::ADDR_ENHANCED, 8'h40);
    for (int m = 0; m < 3; m++) begin
      wr(uart_pins_pkg::ADDR_MODEM_CTRL, m != 0 ? 8'h42 : 8'h02);
      wr(uart_pins_pkg::ADDR_FEATURE, m == 2 ? 8'h04 : 8'h00);
      serial_peer_i.idle(m != 0, m == 2);
      repeat (400) @(posedge clk);
      rd(uart_pins_pkg::ADDR_DATA, d);
      serial_peer_i.sendFrame(8'h5a ^ m[7:0], m != 0, m == 2);
      for (int n = 0; n < 100 && rxReadyN !== 1'b0; n++) @(posedge clk);
      chkBit(rxReadyN, 1'b0);
      chkBit(requestSendN, 1'b1);
      rd(uart_pins_pkg::ADDR_DATA, d);
      chkByte(d, 8'h5a ^ m[7:0]);
      chkBit(rxReadyN, 1'b1);
      chkBit(requestSendN, 1'b0);
    end
    wr(uart_pins_pkg::ADDR_ENHANCED, 8'h00);
    $display("testRx done");
  endtask : testRx
  task automatic endOfTest;
    $display("Counts: %0d checks, %0d mismatches", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : endOfTest
  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    endOfTest;
  end
  initial begin
    {reset_n, regWrite, regRead, regAddr, regWdata} = '0;
    {clearSendN, setReadyN, carrierDetectN, ringIndicateN} = 4'hf;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    testReset;
    testModem;
    testStatus;
    testTxStd;
    testCts;
    testTxIr;
    testRx;
    endOfTest;
  end
endmodule : tb_top
`default_nettype wire

// >>> uart_pin_rx.sv
`timescale 1ns/1ps
`default_nettype none
module uart_pin_rx (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    reset_n,
  // Link to the channel
  rx_link_if.receiver  link
);
  typedef enum logic [1:0] {RxIdle, RxStart, RxData, RxStop} rxState_t;

  logic [1:0]            sync_q;
  uart_pins_pkg::count_t stretch_q, stretch_d;
  uart_pins_pkg::count_t cyc_q, cyc_d;
  logic [3:0]            bits_q, bits_d;
  uart_pins_pkg::byte_t  shift_q, shift_d;
  uart_pins_pkg::byte_t  data_q, data_d;
  logic                  strobe_q, strobe_d;
  rxState_t              state_q, state_d;
  wire logic             pinSync;
  wire logic             irPulse;
  wire logic             line;
  wire logic             cycDone;
  wire uart_pins_pkg::count_t bitReload;

  assign pinSync = sync_q[1];
  assign irPulse = link.rxInvert ? ~pinSync : pinSync;
  // A pulse marks a zero bit; stretching it to a full bit time lets one sampler serve both modes
  assign line    = link.irMode ? (stretch_q == uart_pins_pkg::ZERO_COUNT) : pinSync;
  assign cycDone = (cyc_q == uart_pins_pkg::ZERO_COUNT);
  // The count runs down to zero inclusive, so reload one short or every bit stretches by a cycle
  assign bitReload = uart_pins_pkg::BIT_CYCLES - uart_pins_pkg::ONE_COUNT;
  assign link.rxData   = data_q;
  assign link.rxStrobe = strobe_q;

  always_comb begin
    stretch_d = irPulse ? uart_pins_pkg::BIT_CYCLES
              : (stretch_q == uart_pins_pkg::ZERO_COUNT) ? stretch_q
              : stretch_q - uart_pins_pkg::ONE_COUNT;
    cyc_d     = cycDone ? cyc_q : cyc_q - uart_pins_pkg::ONE_COUNT;
    bits_d    = bits_q;
    shift_d   = shift_q;
    data_d    = data_q;
    strobe_d  = 1'b0;
    state_d   = state_q;
    case (state_q)
      RxIdle: begin
        if (!line) begin
          state_d = RxStart;
          cyc_d   = uart_pins_pkg::HALF_BIT_CYCLES - uart_pins_pkg::ONE_COUNT;
        end
      end
      RxStart: begin
        if (cycDone) begin
          state_d = line ? RxIdle : RxData;
          cyc_d   = bitReload;
          bits_d  = '0;
        end
      end
      RxData: begin
        if (cycDone) begin
          shift_d = {line, shift_q[7:1]};
          bits_d  = bits_q + 4'h1;
          cyc_d   = bitReload;
          if (bits_q == uart_pins_pkg::DATA_BITS - 4'h1) begin
            state_d = RxStop;
          end
        end
      end
      RxStop: begin
        if (cycDone) begin
          state_d = RxIdle;
          if (line) begin
            data_d   = shift_q;
            strobe_d = 1'b1;
          end
        end
      end
      default: state_d = RxIdle;
    endcase
  end

  // Receive input ignored while in reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_q    <= uart_pins_pkg::SYNC_RESET;
      stretch_q <= uart_pins_pkg::ZERO_COUNT;
      cyc_q     <= uart_pins_pkg::ZERO_COUNT;
      bits_q    <= '0;
      shift_q   <= uart_pins_pkg::REG_RESET;
      data_q    <= uart_pins_pkg::REG_RESET;
      strobe_q  <= 1'b0;
      state_q   <= RxIdle;
    end else begin
      sync_q    <= {sync_q[0], link.rxPin};
      stretch_q <= stretch_d;
      cyc_q     <= cyc_d;
      bits_q    <= bits_d;
      shift_q   <= shift_d;
      data_q    <= data_d;
      strobe_q  <= strobe_d;
      state_q   <= state_d;
    end
  end
endmodule : uart_pin_rx
`default_nettype wire

// >>> uart_pins_pkg.sv
package uart_pins_pkg;

  typedef logic [2:0] regAddr_t;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] count_t;

  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned RESET_MIN_NS      = 40;
  localparam int unsigned RESET_MIN_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam count_t BIT_CYCLES      = 8'h10;
  localparam count_t HALF_BIT_CYCLES = 8'h08;
  localparam count_t IR_PULSE_CYCLES = 8'h03;
  localparam count_t ZERO_COUNT      = 8'h00;
  localparam count_t ONE_COUNT       = 8'h01;
  localparam logic [3:0] FRAME_BITS  = 4'ha;
  localparam logic [3:0] DATA_BITS   = 4'h8;

  localparam regAddr_t ADDR_DATA       = 3'h0;
  localparam regAddr_t ADDR_MODEM_CTRL = 3'h1;
  localparam regAddr_t ADDR_FEATURE    = 3'h2;
  localparam regAddr_t ADDR_ENHANCED   = 3'h3;
  localparam regAddr_t ADDR_MODEM_STAT = 3'h4;
  localparam regAddr_t ADDR_IRQ_STATUS = 3'h5;
  localparam regAddr_t ADDR_IRQ_MASK   = 3'h6;
  localparam regAddr_t ADDR_LINE_STAT  = 3'h7;

  localparam int unsigned MCR_DTR  = 0;
  localparam int unsigned MCR_RTS  = 1;
  localparam int unsigned MCR_OP2  = 3;
  localparam int unsigned MCR_IR   = 6;
  localparam int unsigned FEATURE_CONTROL_REG_RXINV = 2;
  localparam int unsigned FEATURE_CONTROL_REG_HALFDUP = 3;
  localparam int unsigned EFR_AUTORTS = 6;
  localparam int unsigned EFR_AUTOCTS = 7;

  localparam int unsigned IRQ_RX_READY = 0;
  localparam int unsigned IRQ_CTS_CHG  = 1;
  localparam int unsigned IRQ_DSR_CHG  = 2;
  localparam int unsigned IRQ_CD_CHG   = 3;
  localparam int unsigned IRQ_RI_CHG   = 4;
  localparam int unsigned IRQ_TX_DONE  = 5;

  localparam byte_t REG_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  function automatic logic regHit(input regAddr_t addr, input regAddr_t target,
                                  input logic strobe);
    regHit = strobe && (addr == target);
  endfunction : regHit

endpackage : uart_pins_pkg

// >>> uart_pins_props.sv
`timescale 1ns/1ps
`default_nettype none
module uart_pins_props (
  // Clock and reset
  input wire logic                    clk, reset_n,
  // Register port
  input wire uart_pins_pkg::regAddr_t regAddr,
  input wire uart_pins_pkg::byte_t    regWdata,
  input wire logic                    regWrite, regRead,
  input wire logic [7:0]              regRdata,
  // Serial and modem pins
  input wire logic                    serialOut, serialIn, requestSendN, clearSendN,
  input wire logic                    terminalReadyN, setReadyN, carrierDetectN,
  input wire logic                    ringIndicateN, irqOut, irqOutEn, outputPortTwoN,
  input wire logic                    rxReadyN
);
  // Shadows of the modem and feature control registers, rebuilt from bus writes
  logic [7:0] modemCtrl_q;
  logic [7:0] featCtrl_q;
  logic [7:0] lowRun_q;
  wire logic  hitModem = regWrite && regAddr == uart_pins_pkg::ADDR_MODEM_CTRL;
  wire logic  hitFeat  = regWrite && regAddr == uart_pins_pkg::ADDR_FEATURE;
  wire logic  readData = regRead && regAddr == uart_pins_pkg::ADDR_DATA;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modemCtrl_q <= 8'h00;
      featCtrl_q  <= 8'h00;
    end else begin
      if (hitModem) modemCtrl_q <= regWdata;
      if (hitFeat) featCtrl_q <= regWdata;
    end
  end
  // Infrared lows are idle, not bits, so the run is cleared there
  always_ff @(posedge clk) begin
    if (!reset_n || serialOut || modemCtrl_q[6]) lowRun_q <= 8'h00;
    else lowRun_q <= lowRun_q + 8'h01;
  end
  sequence irPulse;
    serialOut [*3] ##1 !serialOut;
  endsequence
  a_reset_outputs: assert property ($rose(reset_n) |-> serialOut && requestSendN
    && terminalReadyN && outputPortTwoN && !irqOutEn && !irqOut && rxReadyN)
    else $error("outputs not at reset level");
  a_op2_enable: assert property (irqOutEn == modemCtrl_q[3]
    && outputPortTwoN == !modemCtrl_q[3]) else $error("interrupt enable or port two wrong");
  a_dtr_level: assert property (terminalReadyN == !modemCtrl_q[0])
    else $error("terminal ready does not follow control");
  a_rts_quiet: assert property (!modemCtrl_q[1] && !featCtrl_q[3]
    |-> requestSendN) else $error("request to send asserted without cause");
  a_ir_pulse: assert property (modemCtrl_q[6] && $past(modemCtrl_q[6])
    && $rose(serialOut) |-> irPulse) else $error("infrared pulse not three cycles");
  a_bit_length: assert property (!modemCtrl_q[6] && $rose(serialOut)
    && lowRun_q > 8'h02 |-> lowRun_q[3:0] == 4'h0) else $error("low run not whole bit times");
  a_rx_cleared: assert property (readData |=> rxReadyN)
    else $error("receiver ready still low after data read");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : uart_pins_props
bind uart_serial_modem_pins uart_pins_props uart_pins_props_i (.clk(clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .serialOut(serialOut), .serialIn(serialIn),
  .requestSendN(requestSendN), .clearSendN(clearSendN), .terminalReadyN(terminalReadyN),
  .setReadyN(setReadyN), .carrierDetectN(carrierDetectN), .ringIndicateN(ringIndicateN),
  .irqOut(irqOut), .irqOutEn(irqOutEn), .outputPortTwoN(outputPortTwoN),
  .rxReadyN(rxReadyN));
`default_nettype wire

// >>> uart_serial_modem_pins.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uart_serial_modem_pins (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Register port
  input  wire uart_pins_pkg::regAddr_t  regAddr,
  input  wire uart_pins_pkg::byte_t     regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic [7:0]                    regRdata,
  // Serial line
  output logic                          serialOut,
  input  wire logic                     serialIn,
  // Modem handshake
  output logic                          requestSendN,
  input  wire logic                     clearSendN,
  output logic                          terminalReadyN,
  input  wire logic                     setReadyN,
  input  wire logic                     carrierDetectN,
  input  wire logic                     ringIndicateN,
  // Interrupt and status pins
  output logic                          irqOut,
  output logic                          irqOutEn,
  output logic                          outputPortTwoN,
  output logic                          rxReadyN
);
  typedef enum logic {TxIdle, TxSend} txState_t;

  uart_pins_pkg::byte_t  modemCtrl_q, featureCtrl_q, enhanced_q, irqMask_q;
  uart_pins_pkg::byte_t  irqStatus_q, irqStatus_d;
  uart_pins_pkg::byte_t  txHold_q, rxHold_q, rdata_q, rdata_d;
  logic                  txPending_q, rxFull_q, serialOut_q;
  logic [9:0]            txShift_q;
  logic [3:0]            txBits_q;
  uart_pins_pkg::count_t txCyc_q;
  txState_t              txState_q;
  logic [3:0]            modemS1_q, modemS2_q, modemOld_q;

  wire logic  wrData, wrMcr, wrFctr, wrEfr, wrStat, wrMask, rdData;
  wire logic  irMode, autoCts, autoRts, halfDuplex;
  wire logic  ctsOk, txStart, txBitEnd, txLast, txDone, curBit;
  wire logic  irPulseOn, txLine;
  wire logic  [3:0] modemChg;
  wire uart_pins_pkg::byte_t  irqSet;

  rx_link_if rxLink ();

  uart_pin_rx u_rx (
    .clk     (clk),
    .reset_n (reset_n),
    .link    (rxLink)
  );

  assign wrData = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_DATA, regWrite);
  assign wrMcr  = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_MODEM_CTRL, regWrite);
  assign wrFctr = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_FEATURE, regWrite);
  assign wrEfr  = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_ENHANCED, regWrite);
  assign wrStat = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_IRQ_STATUS, regWrite);
  assign wrMask = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_IRQ_MASK, regWrite);
  assign rdData = uart_pins_pkg::regHit(regAddr, uart_pins_pkg::ADDR_DATA, regRead);

  assign irMode     = modemCtrl_q[uart_pins_pkg::MCR_IR];
  assign autoCts    = enhanced_q[uart_pins_pkg::EFR_AUTOCTS];
  assign autoRts    = enhanced_q[uart_pins_pkg::EFR_AUTORTS];
  assign halfDuplex = featureCtrl_q[uart_pins_pkg::FEATURE_CONTROL_REG_HALFDUP];

  assign rxLink.rxPin    = serialIn;
  assign rxLink.irMode   = irMode;
  assign rxLink.rxInvert = featureCtrl_q[uart_pins_pkg::FEATURE_CONTROL_REG_RXINV];

  // Order: cts, dsr, cd, ri; dsr/cd/ri only feed status bits
  assign ctsOk    = !autoCts || !modemS2_q[0];
  assign txStart  = (txState_q == TxIdle) && txPending_q && ctsOk;
  assign txBitEnd = (txState_q == TxSend) && (txCyc_q == uart_pins_pkg::ONE_COUNT);
  assign txLast   = (txBits_q == uart_pins_pkg::FRAME_BITS - 4'h1);
  assign txDone   = txBitEnd && txLast;
  assign curBit   = txShift_q[0];
  // Zero bits become a short high pulse at the start of the bit
  assign irPulseOn = (txState_q == TxSend) && !curBit &&
                     (txCyc_q > uart_pins_pkg::BIT_CYCLES - uart_pins_pkg::IR_PULSE_CYCLES);
  assign txLine    = irMode ? irPulseOn
                   : ((txState_q == TxSend) ? curBit : 1'b1);

  assign modemChg = modemS2_q ^ modemOld_q;
  assign irqSet   = {2'b00, txDone, modemChg[3], modemChg[2], modemChg[1], modemChg[0],
                     rxLink.rxStrobe};
  // Set wins over a write-one clear in the same cycle
  assign irqStatus_d = (irqStatus_q & ~(wrStat ? regWdata : uart_pins_pkg::REG_RESET)) | irqSet;

  always_comb begin
    case (regAddr)
      uart_pins_pkg::ADDR_DATA:       rdata_d = rxHold_q;
      uart_pins_pkg::ADDR_MODEM_CTRL: rdata_d = modemCtrl_q;
      uart_pins_pkg::ADDR_FEATURE:    rdata_d = featureCtrl_q;
      uart_pins_pkg::ADDR_ENHANCED:   rdata_d = enhanced_q;
      uart_pins_pkg::ADDR_MODEM_STAT: rdata_d = {~modemS2_q, modemChg};
      uart_pins_pkg::ADDR_IRQ_STATUS: rdata_d = irqStatus_q;
      uart_pins_pkg::ADDR_IRQ_MASK:   rdata_d = irqMask_q;
      uart_pins_pkg::ADDR_LINE_STAT:  rdata_d = {5'h00, txPending_q, txState_q == TxSend,
                                                 rxFull_q};
      default:                        rdata_d = uart_pins_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modemCtrl_q   <= uart_pins_pkg::REG_RESET;
      featureCtrl_q <= uart_pins_pkg::REG_RESET;
      enhanced_q    <= uart_pins_pkg::REG_RESET;
      irqMask_q     <= uart_pins_pkg::REG_RESET;
      irqStatus_q   <= uart_pins_pkg::REG_RESET;
      rdata_q       <= uart_pins_pkg::REG_RESET;
    end else begin
      if (wrMcr)  modemCtrl_q   <= regWdata;
      if (wrFctr) featureCtrl_q <= regWdata;
      if (wrEfr)  enhanced_q    <= regWdata;
      if (wrMask) irqMask_q     <= regWdata;
      irqStatus_q <= irqStatus_d;
      rdata_q     <= regRead ? rdata_d : uart_pins_pkg::REG_RESET;
    end
  end

  // Modem inputs idle high after reset so no change is flagged on release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modemS1_q  <= 4'hf;
      modemS2_q  <= 4'hf;
      modemOld_q <= 4'hf;
    end else begin
      modemS1_q  <= {ringIndicateN, carrierDetectN, setReadyN, clearSendN};
      modemS2_q  <= modemS1_q;
      modemOld_q <= modemS2_q;
    end
  end

  // A second write before the frame starts replaces the pending byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txHold_q    <= uart_pins_pkg::REG_RESET;
      txPending_q <= 1'b0;
      rxHold_q    <= uart_pins_pkg::REG_RESET;
      rxFull_q    <= 1'b0;
    end else begin
      if (wrData) txHold_q <= regWdata;
      txPending_q <= wrData || (txPending_q && !txStart);
      if (rxLink.rxStrobe) rxHold_q <= rxLink.rxData;
      rxFull_q <= rxLink.rxStrobe || (rxFull_q && !rdData);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txState_q   <= TxIdle;
      txShift_q   <= 10'h3ff;
      txBits_q    <= '0;
      txCyc_q     <= uart_pins_pkg::ZERO_COUNT;
      serialOut_q <= 1'b1;
    end else begin
      serialOut_q <= txLine;
      if (txStart) begin
        txState_q <= TxSend;
        txShift_q <= {1'b1, txHold_q, 1'b0};
        txBits_q  <= '0;
        txCyc_q   <= uart_pins_pkg::BIT_CYCLES;
      end else if (txState_q == TxSend) begin
        if (txBitEnd) begin
          txShift_q <= {1'b1, txShift_q[9:1]};
          txBits_q  <= txBits_q + 4'h1;
          txCyc_q   <= uart_pins_pkg::BIT_CYCLES;
          if (txLast) txState_q <= TxIdle;
        end else begin
          txCyc_q <= txCyc_q - uart_pins_pkg::ONE_COUNT;
        end
      end
    end
  end

  assign serialOut = serialOut_q;
  // Half-duplex owns the pin; otherwise automatic mode also needs room in the holding register
  assign requestSendN = halfDuplex ? !(txState_q == TxSend)
                      : !(modemCtrl_q[uart_pins_pkg::MCR_RTS] && !(autoRts && rxFull_q));
  assign terminalReadyN = !modemCtrl_q[uart_pins_pkg::MCR_DTR];
  assign irqOut         = |(irqStatus_q & irqMask_q);
  assign irqOutEn       = modemCtrl_q[uart_pins_pkg::MCR_OP2];
  assign outputPortTwoN = !modemCtrl_q[uart_pins_pkg::MCR_OP2];
  assign rxReadyN       = !rxFull_q;
  assign regRdata       = rdata_q;
endmodule : uart_serial_modem_pins
`default_nettype wire
